// [core/ccd_consts.vh]
`ifndef CCD_CONSTS_VH
`define CCD_CONSTS_VH

// ============================================================
// Register byte offsets on the APB window.
`define CCD_OFS_CORE_CONTROL 8'h00
`define CCD_OFS_FLAGS        8'h04
`define CCD_OFS_COMMAND      8'h08
`define CCD_OFS_READ_EA      8'h0c
`define CCD_OFS_WRITE_EA     8'h10
`define CCD_OFS_MEM_DATA     8'h14
`define CCD_OFS_STATUS       8'h18
`define CCD_OFS_WIN_PAGE     8'h1c
`define CCD_OFS_TABLE_PAGE   8'h20
`define CCD_OFS_TABLE_OFFSET 8'h24
`define CCD_OFS_TABLE_DATA   8'h28
`define CCD_OFS_PC           8'h2c
`define CCD_OFS_WREG_BASE    8'h40

// ============================================================
// Core control fields and reset value.
`define CCD_CC_PRIO_MSB   3
`define CCD_CC_WIN_EN     2
`define CCD_CC_RESET      16'h0000

// ============================================================
// Flag register fields.
`define CCD_FL_HALF       8
`define CCD_FL_PRIO_HI    7
`define CCD_FL_PRIO_LO    5
`define CCD_FL_RA         4
`define CCD_FL_N          3
`define CCD_FL_OVF        2
`define CCD_FL_Z          1
`define CCD_FL_C          0
`define CCD_FL_WMASK      16'h01ef
`define CCD_FL_RESET      16'h0000

// ============================================================
// Status fields.
`define CCD_ST_ADDR_ERR   0
`define CCD_ST_DIV_BUSY   1
`define CCD_ST_DIV_DONE   2

// ============================================================
// Command word fields and operation codes.
`define CCD_CMD_OP_HI     3
`define CCD_CMD_DST_HI    7
`define CCD_CMD_SRCA_HI   11
`define CCD_CMD_SRCB_HI   15
`define CCD_CMD_BYTE      16
`define CCD_CMD_SRC_MEM   17
`define CCD_CMD_DST_MEM   18
`define CCD_CMD_MODE_HI   21
`define CCD_CMD_LIT_HI    26
`define CCD_OP_ADD        4'h0
`define CCD_OP_SUB        4'h1
`define CCD_OP_AND        4'h2
`define CCD_OP_OR         4'h3
`define CCD_OP_XOR        4'h4
`define CCD_OP_SHIFT      4'h5
`define CCD_OP_MUL        4'h6
`define CCD_OP_DIV32      4'h7
`define CCD_OP_DIV16      4'h8
`define CCD_MUL_UU        3'h0
`define CCD_MUL_SS        3'h1
`define CCD_MUL_US        3'h2
`define CCD_MUL_SU        3'h3
`define CCD_MUL_SLIT      3'h4
`define CCD_MUL_ULIT      3'h5
`define CCD_MUL_BYTE      3'h6

// ============================================================
// Address space and timing.
`define CCD_EA_BYTE_MODE  16
`define CCD_DMEM_WORDS    1024
`define CCD_RESET_PC      23'h000000
`define CCD_RESET_TARGET  24'h000002
`define CCD_VECTOR_END    23'h000200
`define CCD_IVT_START     23'h000004
`define CCD_AIVT_START    23'h000100
`define CCD_AIVT_END      23'h0001ff
`define CCD_PC_STEP       23'h000002
`define CCD_DIV_STEPS     5'd16
`define CCD_DIV_LAST      5'd18

`endif

// [core/ccd_consts_unused_placeholder.v]
`default_nettype none
`default_nettype wire

// [core/ccd_core.v]
// Overview of operation
// - Clear-only priority MSB extends flag priority.
// - Control bit two enables program window.
// - Unused control bits read as zero.
// - Sixteen-bit two's complement add, sub, logic.
// - Arithmetic updates carry, zero, sign, overflow flags.
// - Byte or word operands, registers or memory.
// - Seventeen-bit multiplier with seven sign modes.
// - Signed/unsigned 32/16 and 16/16 division.
// - Quotient to register zero, remainder one.
// - Any divisor register, aligned dividend pair.
// - One divide step per divisor bit.
// - Nineteen-cycle divide, interruptible without loss.
// - Single-cycle shift up to sixteen bits.
// - Signed count: positive right, negative left.
// - 24-bit program address from 23-bit counter.
// - User access below 0x7fffff except table.
// - Program counter steps by two.
// - Reset starts at zero, vectors below 0x200.
// - Two interrupt vector tables decoded.
// - Separate read and write address generators.
// - Effective address bit 15 selects window.
// - Unimplemented data space reads as zero.
// - Low byte even, high byte odd.
// - Misaligned word traps, write suppressed.
//
// Added by the designer: register access over APB and the register offsets.
`include "ccd_consts.vh"
`default_nettype none

module ccd_core (
  // Clock and reset
  input  wire        clock,
  input  wire        sys_rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Program sequencing
  input  wire        pc_advance,
  input  wire        pc_load,
  input  wire [22:0] pc_target,
  input  wire        priority_raise,
  input  wire        irq_hold,
  // Program memory side
  output wire [23:0] fetch_addr,
  output wire [23:0] table_addr,
  output wire [23:0] win_addr,
  input  wire [23:0] table_rdata,
  input  wire [15:0] win_rdata,
  // Status outputs
  output wire [3:0]  priority_level,
  output wire [1:0]  pc_region,
  output wire        address_error
);

  // ============================================================
  // State.
  reg  [15:0] wreg [0:15];
  reg  [15:0] dmem [0:`CCD_DMEM_WORDS-1];
  reg         priority_level_msb;
  reg         program_space_window_enable;
  reg  [15:0] cpu_flags_register;
  reg  [16:0] read_ea;
  reg  [16:0] write_ea;
  reg  [7:0]  win_page;
  reg  [7:0]  table_page;
  reg  [15:0] table_offset;
  reg  [22:0] program_counter;
  reg         addr_err;
  reg         div_done_flag;
  reg         bad_addr;
  integer     i;

  localparam [15:0] CC_RST = `CCD_CC_RESET;

  // ============================================================
  // APB decode.
  wire setup_rd = psel & ~penable & ~pwrite;
  wire setup_go = psel & ~penable;
  wire wr_en    = psel & penable & pwrite;
  wire is_wreg  = paddr[7:6] == 2'b01;
  wire [3:0] wsel = paddr[5:2];

  assign pready  = 1'b1;
  assign pslverr = psel & penable & bad_addr;

  // ============================================================
  // Command fields, taken straight from the write data.
  wire [3:0] op      = pwdata[`CCD_CMD_OP_HI:0];
  wire [3:0] dst     = pwdata[`CCD_CMD_DST_HI:4];
  wire [3:0] srca    = pwdata[`CCD_CMD_SRCA_HI:8];
  wire [3:0] srcb    = pwdata[`CCD_CMD_SRCB_HI:12];
  wire       bmode   = pwdata[`CCD_CMD_BYTE];
  wire       src_mem = pwdata[`CCD_CMD_SRC_MEM];
  wire       dst_mem = pwdata[`CCD_CMD_DST_MEM];
  wire [2:0] mode    = pwdata[`CCD_CMD_MODE_HI:19];
  wire [4:0] lit     = pwdata[`CCD_CMD_LIT_HI:22];
  wire       cmd_wr  = wr_en & (paddr == `CCD_OFS_COMMAND);
  wire       div_busy;

  // ============================================================
  // Data space read path.
  // Independent read generator.
  wire [15:0] rea      = read_ea[15:0];
  wire        rd_byte  = read_ea[`CCD_EA_BYTE_MODE];
  wire        rd_inmem = rea[14:11] == 4'h0;
  reg  [15:0] rd_word;
  reg  [15:0] rd_val;

  assign win_addr = {1'b0, win_page, rea[14:0]};

  always @* begin
    if (rea[15]) begin
      rd_word = program_space_window_enable ? win_rdata : 16'h0000;
    end else if (rd_inmem) begin
      rd_word = dmem[rea[10:1]];
    end else begin
      rd_word = 16'h0000;
    end
    if (rd_byte) begin
      rd_val = {8'h00, rea[0] ? rd_word[15:8] : rd_word[7:0]};
    end else begin
      rd_val = rd_word;
    end
  end

  wire rd_misalign = ~rd_byte & rea[0];
  wire wr_misalign = ~write_ea[`CCD_EA_BYTE_MODE] & write_ea[0];

  // ============================================================
  // Arithmetic unit.
  // Operand select and width.
  wire [15:0] opa   = wreg[srca];
  wire [15:0] opb_r = src_mem ? rd_val : wreg[srcb];
  wire [15:0] a     = bmode ? {8'h00, opa[7:0]} : opa;
  wire [15:0] b     = bmode ? {8'h00, opb_r[7:0]} : opb_r;
  wire        sub   = op == `CCD_OP_SUB;
  wire [15:0] bx    = sub ? ~b : b;
  wire [4:0]  s_nib = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, sub};
  wire [8:0]  s_lo  = {1'b0, a[7:0]} + {1'b0, bx[7:0]} + {8'h00, sub};
  wire [8:0]  s_hi  = {1'b0, a[15:8]} + {1'b0, bx[15:8]} + {8'h00, s_lo[8]};
  wire [15:0] shres;

  ccd_shifter u_shift (
    .operand (b),
    .count   (wreg[srca][5:0]),
    .arith   (mode[0]),
    .result  (shres)
  );

  reg  [15:0] alu_res;
  reg         c_new;
  reg         half_new;
  reg         ovf_new;
  reg         arith_op;

  always @* begin
    arith_op = (op == `CCD_OP_ADD) | sub;
    case (op)
      `CCD_OP_ADD, `CCD_OP_SUB: alu_res = {s_hi[7:0], s_lo[7:0]};
      `CCD_OP_AND:              alu_res = a & b;
      `CCD_OP_OR:               alu_res = a | b;
      `CCD_OP_XOR:              alu_res = a ^ b;
      `CCD_OP_SHIFT:            alu_res = shres;
      default:                  alu_res = 16'h0000;
    endcase
    // Carry and digit carry; borrow is inverted carry.
    if (bmode) begin
      c_new    = s_lo[8];
      half_new = s_nib[4];
      ovf_new  = (a[7] == bx[7]) & (s_lo[7] != a[7]);
    end else begin
      c_new    = s_hi[8];
      half_new = s_lo[8];
      ovf_new  = (a[15] == bx[15]) & (s_hi[7] != a[15]);
    end
  end

  wire res_neg  = bmode ? alu_res[7] : alu_res[15];
  wire res_zero = bmode ? (alu_res[7:0] == 8'h00) : (alu_res == 16'h0000);
  wire alu_op   = op <= `CCD_OP_SHIFT;

  // ============================================================
  // Multiplier.
  // Seventeen-bit signed core.
  reg  [15:0] ma;
  reg  [15:0] mb;
  reg         sa;
  reg         sb;

  always @* begin
    ma = opa;
    mb = opb_r;
    sa = 1'b0;
    sb = 1'b0;
    case (mode)
      `CCD_MUL_UU: begin
        sa = 1'b0;
      end
      `CCD_MUL_SS: begin
        sa = 1'b1;
        sb = 1'b1;
      end
      `CCD_MUL_US: begin
        sb = 1'b1;
      end
      `CCD_MUL_SU: begin
        sa = 1'b1;
      end
      `CCD_MUL_SLIT: begin
        sa = 1'b1;
        mb = {11'h000, lit};
      end
      `CCD_MUL_ULIT: begin
        mb = {11'h000, lit};
      end
      `CCD_MUL_BYTE: begin
        ma = {8'h00, opa[7:0]};
        mb = {8'h00, opb_r[7:0]};
      end
      default: begin
        sa = 1'b0;
      end
    endcase
  end

  wire signed [16:0] ma17 = {sa & ma[15], ma};
  wire signed [16:0] mb17 = {sb & mb[15], mb};
  wire signed [33:0] prod = ma17 * mb17;
  wire [3:0]  dst_lo = {dst[3:1], 1'b0};
  wire [3:0]  dst_hi = {dst[3:1], 1'b1};

  // ============================================================
  // Divider.
  // Any divisor, aligned even/odd pair.
  wire [3:0]  pair_lo = {srca[3:1], 1'b0};
  wire [3:0]  pair_hi = {srca[3:1], 1'b1};
  wire        sdiv    = mode[0];
  wire [15:0] d16     = wreg[srca];
  wire [31:0] dvd32   = {wreg[pair_hi], wreg[pair_lo]};
  wire [31:0] dvd16   = {sdiv & d16[15] ? 16'hffff : 16'h0000, d16};
  wire        div_go  = cmd_wr & ~div_busy &
                        ((op == `CCD_OP_DIV32) | (op == `CCD_OP_DIV16));
  wire        div_done;
  wire [15:0] div_q;
  wire [15:0] div_r;

  ccd_divider u_div (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .start     (div_go),
    .hold      (irq_hold),
    .is_signed (sdiv),
    .dividend  (op == `CCD_OP_DIV32 ? dvd32 : dvd16),
    .divisor   (wreg[srcb]),
    .busy      (div_busy),
    .done      (div_done),
    .quotient  (div_q),
    .remainder (div_r)
  );

  wire cmd_ok = cmd_wr & ~div_busy;

  // ============================================================
  // Working registers.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < 16; i = i + 1) begin
        wreg[i] <= 16'h0000;
      end
    end else begin
      if (wr_en && is_wreg) begin
        wreg[wsel] <= pwdata[15:0];
      end
      if (cmd_ok && alu_op && !dst_mem) begin
        // Byte results leave the upper byte alone.
        if (bmode) begin
          wreg[dst][7:0] <= alu_res[7:0];
        end else begin
          wreg[dst] <= alu_res;
        end
      end
      if (cmd_ok && op == `CCD_OP_MUL) begin
        wreg[dst_lo] <= prod[15:0];
        wreg[dst_hi] <= prod[31:16];
      end
      if (div_done) begin
        wreg[0] <= div_q;
        wreg[1] <= div_r;
      end
    end
  end

  // ============================================================
  // Data memory writes.
  // Independent write generator.
  wire        mem_wr_apb = wr_en & (paddr == `CCD_OFS_MEM_DATA);
  wire        mem_wr_alu = cmd_ok & alu_op & dst_mem;
  wire        mem_wr     = mem_wr_apb | mem_wr_alu;
  wire [15:0] wdat       = mem_wr_alu ? alu_res : pwdata[15:0];
  wire        wr_byte    = write_ea[`CCD_EA_BYTE_MODE];
  wire        wr_inmem   = ~write_ea[15] & (write_ea[14:11] == 4'h0);

  always @(posedge clock) begin
    if (mem_wr && wr_inmem && !wr_misalign) begin
      if (!wr_byte) begin
        dmem[write_ea[10:1]] <= wdat;
      // Byte lane by address bit zero.
      end else if (write_ea[0]) begin
        dmem[write_ea[10:1]][15:8] <= wdat[7:0];
      end else begin
        dmem[write_ea[10:1]][7:0] <= wdat[7:0];
      end
    end
  end

  // ============================================================
  // Control, flags and address registers.
  wire rd_use  = (setup_rd & (paddr == `CCD_OFS_MEM_DATA)) |
                 (cmd_ok & alu_op & src_mem);
  wire err_hit = (rd_use & rd_misalign) | (mem_wr & wr_misalign);

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      priority_level_msb          <= CC_RST[`CCD_CC_PRIO_MSB];
      program_space_window_enable <= CC_RST[`CCD_CC_WIN_EN];
      cpu_flags_register          <= `CCD_FL_RESET;
      read_ea                     <= 17'h00000;
      write_ea                    <= 17'h00000;
      win_page                    <= 8'h00;
      table_page                  <= 8'h00;
      table_offset                <= 16'h0000;
      addr_err                    <= 1'b0;
      div_done_flag               <= 1'b0;
    end else begin
      if (priority_raise) begin
        priority_level_msb <= 1'b1;
      end else if (wr_en && paddr == `CCD_OFS_CORE_CONTROL &&
                   !pwdata[`CCD_CC_PRIO_MSB]) begin
        priority_level_msb <= 1'b0;
      end
      if (wr_en && paddr == `CCD_OFS_CORE_CONTROL) begin
        program_space_window_enable <= pwdata[`CCD_CC_WIN_EN];
      end
      if (wr_en && paddr == `CCD_OFS_FLAGS) begin
        cpu_flags_register <= pwdata[15:0] & `CCD_FL_WMASK;
      end else if (cmd_ok && alu_op) begin
        cpu_flags_register[`CCD_FL_N] <= res_neg;
        cpu_flags_register[`CCD_FL_Z] <= res_zero;
        if (arith_op) begin
          cpu_flags_register[`CCD_FL_C]  <= c_new;
          cpu_flags_register[`CCD_FL_HALF] <= half_new;
          cpu_flags_register[`CCD_FL_OVF]  <= ovf_new;
        end
      end
      if (wr_en && paddr == `CCD_OFS_READ_EA) begin
        read_ea <= pwdata[16:0];
      end
      if (wr_en && paddr == `CCD_OFS_WRITE_EA) begin
        write_ea <= pwdata[16:0];
      end
      if (wr_en && paddr == `CCD_OFS_WIN_PAGE) begin
        win_page <= pwdata[7:0];
      end
      if (wr_en && paddr == `CCD_OFS_TABLE_PAGE) begin
        table_page <= pwdata[7:0];
      end
      if (wr_en && paddr == `CCD_OFS_TABLE_OFFSET) begin
        table_offset <= pwdata[15:0];
      end
      if (err_hit) begin
        addr_err <= 1'b1;
      end else if (wr_en && paddr == `CCD_OFS_STATUS &&
                   pwdata[`CCD_ST_ADDR_ERR]) begin
        addr_err <= 1'b0;
      end
      if (div_done) begin
        div_done_flag <= 1'b1;
      end else if (wr_en && paddr == `CCD_OFS_STATUS &&
                   pwdata[`CCD_ST_DIV_DONE]) begin
        div_done_flag <= 1'b0;
      end
    end
  end

  // ============================================================
  // Program counter and program address.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      program_counter <= `CCD_RESET_PC;
    end else if (pc_load) begin
      program_counter <= {pc_target[22:1], 1'b0};
    end else if (pc_advance) begin
      program_counter <= program_counter + `CCD_PC_STEP;
    end
  end

  assign fetch_addr = {1'b0, program_counter};
  // Only table access reaches the upper half.
  assign table_addr = {table_page, table_offset};

  assign pc_region = (program_counter >= `CCD_VECTOR_END) ? 2'd0 :
                     (program_counter <  `CCD_IVT_START)  ? 2'd1 :
                     (program_counter <  `CCD_AIVT_START) ? 2'd2 : 2'd3;

  assign priority_level = {priority_level_msb,
                           cpu_flags_register[`CCD_FL_PRIO_HI:`CCD_FL_PRIO_LO]};
  assign address_error  = addr_err;

  // ============================================================
  // Read data, captured in the setup cycle.
  wire [15:0] flags_rd = cpu_flags_register |
                         ({15'h0000, div_busy} << `CCD_FL_RA);
  reg  [31:0] next_prdata;
  reg         next_bad;

  always @* begin
    next_prdata = 32'h00000000;
    next_bad    = 1'b0;
    if (is_wreg) begin
      next_prdata = {16'h0000, wreg[wsel]};
    end else begin
      case (paddr)
        // Only bits 3 and 2 are live.
        `CCD_OFS_CORE_CONTROL: next_prdata = {28'h0000000,
                                 priority_level_msb,
                                 program_space_window_enable, 2'b00};
        `CCD_OFS_FLAGS:        next_prdata = {16'h0000, flags_rd};
        `CCD_OFS_COMMAND:      next_prdata = 32'h00000000;
        `CCD_OFS_READ_EA:      next_prdata = {15'h0000, read_ea};
        `CCD_OFS_WRITE_EA:     next_prdata = {15'h0000, write_ea};
        `CCD_OFS_MEM_DATA:     next_prdata = {16'h0000, rd_val};
        `CCD_OFS_STATUS:       next_prdata = {29'h00000000, div_done_flag,
                                              div_busy, addr_err};
        `CCD_OFS_WIN_PAGE:     next_prdata = {24'h000000, win_page};
        `CCD_OFS_TABLE_PAGE:   next_prdata = {24'h000000, table_page};
        `CCD_OFS_TABLE_OFFSET: next_prdata = {16'h0000, table_offset};
        `CCD_OFS_TABLE_DATA:   next_prdata = {8'h00, table_rdata};
        `CCD_OFS_PC:           next_prdata = {9'h000, program_counter};
        default:               next_bad    = 1'b1;
      endcase
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prdata   <= 32'h00000000;
      bad_addr <= 1'b0;
    end else if (setup_go) begin
      bad_addr <= next_bad;
      if (setup_rd) begin
        prdata <= next_prdata;
      end
    end
  end

endmodule // ccd_core

`default_nettype wire

// [core/ccd_divider.v]
`include "ccd_consts.vh"
`default_nettype none

module ccd_divider (
  // Clock and reset
  input  wire        clock,
  input  wire        sys_rst,
  // Request
  input  wire        start,
  input  wire        hold,
  input  wire        is_signed,
  input  wire [31:0] dividend,
  input  wire [15:0] divisor,
  // Answer
  output reg         busy,
  output reg         done,
  output reg  [15:0] quotient,
  output reg  [15:0] remainder
);

  reg  [4:0]  cnt;
  reg  [15:0] part;
  reg  [15:0] qbits;
  reg  [15:0] dsr;
  reg         neg_q;
  reg         neg_r;

  wire        dvd_neg = is_signed & dividend[31];
  wire        dsr_neg = is_signed & divisor[15];
  wire [31:0] dvd_abs = dvd_neg ? (~dividend + 32'h1) : dividend;
  wire [15:0] dsr_abs = dsr_neg ? (~divisor + 16'h1) : divisor;
  wire [16:0] trial   = {part, qbits[15]};
  wire        fits    = trial >= {1'b0, dsr};
  wire [16:0] diff    = trial - {1'b0, dsr};

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      busy      <= 1'b0;
      done      <= 1'b0;
      cnt       <= 5'd0;
      part      <= 16'h0000;
      qbits     <= 16'h0000;
      dsr       <= 16'h0000;
      neg_q     <= 1'b0;
      neg_r     <= 1'b0;
      quotient  <= 16'h0000;
      remainder <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy  <= 1'b1;
        cnt   <= 5'd0;
        part  <= dvd_abs[31:16];
        qbits <= dvd_abs[15:0];
        dsr   <= dsr_abs;
        neg_q <= dvd_neg ^ dsr_neg;
        neg_r <= dvd_neg;
      end else if (busy && !hold) begin
        cnt <= cnt + 5'd1;
        if (cnt >= 5'd1 && cnt <= `CCD_DIV_STEPS) begin
          part  <= fits ? diff[15:0] : trial[15:0];
          qbits <= {qbits[14:0], fits};
        end else if (cnt == `CCD_DIV_STEPS + 5'd1) begin
          quotient  <= neg_q ? (~qbits + 16'h1) : qbits;
          remainder <= neg_r ? (~part + 16'h1) : part;
        end else if (cnt == `CCD_DIV_LAST) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule // ccd_divider

`default_nettype wire

// [core/ccd_shifter.v]
`include "ccd_consts.vh"
`default_nettype none

module ccd_shifter (
  // Operand and signed count
  input  wire [15:0] operand,
  input  wire [5:0]  count,
  input  wire        arith,
  // Result
  output reg  [15:0] result
);

  wire [5:0] mag = count[5] ? (~count + 6'h01) : count;
  wire [4:0] amt = (mag > 6'h10) ? 5'h10 : mag[4:0];

  always @* begin
    if (count == 6'h00) begin
      result = operand;
    end else if (!count[5]) begin
      if (arith) begin
        result = $signed(operand) >>> amt;
      end else begin
        result = operand >> amt;
      end
    end else begin
      result = operand << amt;
    end
  end

endmodule // ccd_shifter

`default_nettype wire

// [verification/ccd_core_bench.sv]
`default_nettype none
module ccd_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, address_error;
  logic pc_advance, pc_load, priority_raise, irq_hold;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, lf, p;
  logic [22:0] pc_target;
  logic [23:0] fetch_addr, table_addr, win_addr, table_rdata;
  logic [15:0] win_rdata, a, b, c;
  logic [3:0]  priority_level, op;
  logic [1:0]  pc_region;
  logic [31:0] q[$];
  int          n_errors, cmp_count, i;
  // Script entries are write flag, offset, then write data or expected read data.
  logic [40:0] scr[23] = '{41'h00000000000, 41'h100ffffffff, 41'h00000000004,
    41'h10c00008000, 41'h01400005a3c, 41'h10000000000, 41'h01400000000,
    41'h11000000010, 41'h11400001234, 41'h10c00010011, 41'h01400000012,
    41'h10c00001000, 41'h01400000000, 41'h11000000011, 41'h1140000beef,
    41'h01800000001, 41'h10c00000010, 41'h01400001234, 41'h03000000000,
    41'h02800123456, 41'h104ffffffff, 41'h004000001ef, 41'h10400000000};
  ccd_core dut_u (.*);
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic test_done;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // ==========
  // Bus master; a read leaves its expected value for the watcher.
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int t;
    if (!w) q.push_back(d);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock) penable <= 1;
    t = 0;
    do begin
      @(posedge clock);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      test_done();
    end
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  always @(posedge clock) begin
    if (psel && penable && pready) chk("pslverr", pslverr, paddr == 8'h30);
    if (psel && penable && !pwrite && pready) chk("prdata", prdata, q.pop_front());
  end
  initial begin
    {psel, penable, pwrite, pc_advance, pc_load, priority_raise, irq_hold} = 0;
    paddr = 0;
    pwdata = 0;
    lf = 3;
    pc_target = 23'h101;
    table_rdata = 24'h123456;
    win_rdata = 16'h5a3c;
    sys_rst = 1;
    repeat (2) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    foreach (scr[j]) xfer(scr[j][40], scr[j][39:32], scr[j][31:0]);
    xfer(1, 8'h1c, 32'h5a);
    xfer(1, 8'h24, 32'h1234);
    xfer(1, 8'h20, 32'h80);
    chk("win_addr", win_addr, {1'b0, 8'h5a, 15'h10});
    chk("table_addr", table_addr, 32'h801234);
    chk("address_error", address_error, 1);
    priority_raise <= 1;
    @(posedge clock) priority_raise <= 0;
    xfer(0, 8'h00, 32'h8);
    xfer(1, 8'h00, 32'h8);
    xfer(0, 8'h00, 32'h8);
    xfer(1, 8'h00, 0);
    xfer(0, 8'h00, 0);
    xfer(0, 8'h2c, 0);
    pc_advance <= 1;
    repeat (3) @(posedge clock);
    pc_advance <= 0;
    xfer(0, 8'h2c, 6);
    pc_load <= 1;
    @(posedge clock) pc_load <= 0;
    xfer(0, 8'h2c, 32'h100);
    for (i = 0; i < 10; i++) begin
      lf = nx(lf);
      op = i < 5 ? 4'(i) : (i < 8 ? 4'h5 : 4'h6);
      a = op != 5 ? lf[15:0] : (i == 5 ? 16'h4 : (i == 6 ? 16'hfffc : 16'h0));
      b = lf[31:16];
      p = i == 9 ? 32'($signed(a) * $signed(b)) : a * b;
      c = op == 0 ? a + b : op == 1 ? a - b : op == 2 ? a & b : op == 3 ? a | b :
        op == 4 ? a ^ b : i == 5 ? 16'($signed(b) >>> 4) : i == 6 ? b << 4 :
        i == 7 ? b : p[15:0];
      xfer(1, 8'h48, 32'(a));
      xfer(1, 8'h4c, 32'(b));
      xfer(1, 8'h08, {10'h0, i == 9 || i == 5 ? 3'h1 : 3'h0, 15'h324, op});
      xfer(0, 8'h50, 32'(c));
      if (op == 6) xfer(0, 8'h54, 32'(p[31:16]));
    end
    xfer(1, 8'h48, 32'hffff);
    xfer(1, 8'h4c, 32'h1);
    xfer(1, 8'h08, 32'h3240);
    xfer(0, 8'h04, 32'h103);
    xfer(1, 8'h08, 32'h13241);
    xfer(0, 8'h50, 32'hfe);
    xfer(0, 8'h04, 32'h109);
    for (i = 0; i < 2; i++) begin
      lf = nx(lf);
      p = {lf[31:16] & 16'h7fff, lf[15:0]};
      a = lf[15:0] | 16'h8000;
      xfer(1, 8'h18, 32'h4);
      xfer(1, 8'h58, 32'(a));
      xfer(1, 8'h4c, 32'(p[31:16]));
      xfer(1, 8'h48, 32'(p[15:0]));
      xfer(1, 8'h08, 32'h6207);
      irq_hold <= i[0];
      repeat (5) @(posedge clock);
      irq_hold <= 0;
      repeat (21) @(posedge clock);
      xfer(0, 8'h18, 32'h5);
      xfer(0, 8'h40, p / a);
      xfer(0, 8'h44, p % a);
    end
    test_done();
  end
endmodule // ccd_core_bench
`default_nettype wire

// [verification/ccd_core_chk.sv]
`default_nettype none
module ccd_core_chk (
  input wire logic clock, sys_rst, psel, penable, pwrite, pc_advance, pc_load, priority_raise,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [22:0] pc_target,
  input wire logic [23:0] fetch_addr,
  input wire logic [3:0]  priority_level,
  input wire logic [1:0]  pc_region
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ==========
  // Control register and program counter.
  AST_CC_ZERO: assert property (
    psel && penable && !pwrite && paddr == 8'h0 |-> (prdata & 32'hfffffff3) == 0)
    else $error("unused bits set");
  AST_PRIO_SET: assert property (priority_raise |=> priority_level[3])
    else $error("msb not set");
  AST_PRIO_WR: assert property (
    psel && penable && pwrite && paddr == 8'h0 && !priority_raise
    && !(pwdata[3] && priority_level[3]) |=> !priority_level[3])
    else $error("msb set by write");
  AST_PRIO_ONE: assert property (
    psel && penable && pwrite && paddr == 8'h0 && pwdata[3] && !priority_raise
    |=> priority_level[3] == $past(priority_level[3]))
    else $error("msb changed by a one write");
  AST_PC_STEP: assert property (
    pc_advance && !pc_load |=> fetch_addr[22:0] == $past(fetch_addr[22:0]) + 23'h2)
    else $error("bad pc step");
  AST_PC_LOAD: assert property (
    pc_load |=> fetch_addr == {1'b0, $past(pc_target[22:1]), 1'b0})
    else $error("bad pc load");
  AST_PC_FORM: assert property (!fetch_addr[23] && !fetch_addr[0])
    else $error("bad fetch address");
  AST_RESET_PC: assert property (
    $fell(sys_rst) |-> fetch_addr == 24'h0 && pc_region == 2'd1)
    else $error("bad reset pc");
  AST_REGION: assert property (
    fetch_addr < 24'h200 |-> pc_region == (fetch_addr < 24'h4 ? 2'd1 :
      (fetch_addr < 24'h100 ? 2'd2 : 2'd3)))
    else $error("bad region");
endmodule // ccd_core_chk
bind ccd_core ccd_core_chk chk_u (.*);
`default_nettype wire
